// ===== hdl/sea_eeprom.sv
// Serial EEPROM slave: bus engine on scl, write engine on clock
`timescale 1ns/1ps
`default_nettype none
module sea_eeprom #(
    parameter int WRITE_CYCLES = sea_pkg::WRITE_CYCLES,
    parameter logic [3:0] DEV_CODE = 4'h5 // Arbitrary value
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic chip_select_pin_0,
    input wire logic chip_select_pin_1,
    input wire logic chip_select_pin_2,
    input wire logic write_protect,
    output logic write_busy
);

    // Start and stop detectors, clocked by the data line itself
    logic start_tgl_r;
    logic stop_tgl_r;

    always_ff @(negedge sda_i or negedge rstn) begin
        if (!rstn) begin
            start_tgl_r <= 1'b0;
        end else if (scl) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    always_ff @(posedge sda_i or negedge rstn) begin
        if (!rstn) begin
            stop_tgl_r <= 1'b0;
        end else if (scl) begin
            stop_tgl_r <= ~stop_tgl_r;
        end
    end

    // Link domain state
    sea_pkg::sea_link_st_t st_r, st_nxt;
    sea_pkg::sea_page_t pg_r, pg_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [11:0] ptr_r, ptr_nxt;
    logic ack_r, ack_nxt;
    logic first_r, first_nxt;
    logic start_seen_r;
    logic busy_m_r, busy_s_r;
    logic [2:0] cs_m_r, cs_s_r;
    logic oe_r;
    logic [7:0] rd_q;
    logic busy_r;

    wire new_start = start_tgl_r != start_seen_r;
    wire [7:0] byte_w = {shift_r[6:0], sda_i};
    wire at_last = bit_r == sea_pkg::BIT_LAST && !new_start;
    wire at_ack = bit_r == sea_pkg::BIT_ACK && !new_start;
    wire code_ok = byte_w[7:4] == DEV_CODE;
    wire cs_ok = byte_w[3:1] == cs_s_r;
    wire sel = code_ok && cs_ok && !busy_s_r;
    wire load_rd = at_ack && st_r == sea_pkg::LK_READ && (first_r || !sda_i);
    wire buf_we = at_last && st_r == sea_pkg::LK_WDATA;
    wire [4:0] low_inc = ptr_r[4:0] + 5'h01;
    wire [11:0] ptr_inc = ptr_r + 12'h001;
    wire drv_ack = bit_r == sea_pkg::BIT_ACK && ack_r;
    wire drv_bit = st_r == sea_pkg::LK_READ && !first_r && bit_r < sea_pkg::BIT_ACK
        && !tx_r[3'h7 - bit_r[2:0]];

    always_comb begin
        st_nxt = st_r;
        ack_nxt = ack_r;
        ptr_nxt = ptr_r;
        first_nxt = first_r;
        pg_nxt = pg_r;
        bit_nxt = bit_r + 4'h1;
        if (at_ack) begin
            bit_nxt = 4'h0;
        end
        if (new_start) begin
            bit_nxt = sea_pkg::BIT_FIRST;
            st_nxt = sea_pkg::LK_CTRL;
            ack_nxt = 1'b0;
            first_nxt = 1'b0;
        end else if (at_last) begin
            ack_nxt = 1'b0;
            unique case (st_r)
                sea_pkg::LK_IDLE, sea_pkg::LK_READ: begin
                    st_nxt = st_r;
                end
                sea_pkg::LK_CTRL: begin
                    // Old page is done with once a new command is addressed
                    pg_nxt.pending = 1'b0;
                    if (sel) begin // see R21 see R22 see R5 see R14
                        ack_nxt = 1'b1;
                        first_nxt = byte_w[0]; // see R15
                        st_nxt = byte_w[0] ? sea_pkg::LK_READ : sea_pkg::LK_ADRH; // see R3
                    end else begin
                        st_nxt = sea_pkg::LK_IDLE;
                    end
                end
                sea_pkg::LK_ADRH: begin
                    ptr_nxt[11:8] = byte_w[3:0]; // see R4 see R23
                    ack_nxt = 1'b1;
                    st_nxt = sea_pkg::LK_ADRL;
                end
                sea_pkg::LK_ADRL: begin
                    ptr_nxt[7:0] = byte_w; // see R4 see R17
                    ack_nxt = 1'b1;
                    pg_nxt.mask = '0;
                    st_nxt = sea_pkg::LK_WDATA;
                end
                sea_pkg::LK_WDATA: begin
                    // Only the low bits move, so the page never changes
                    ptr_nxt = {ptr_r[11:5], low_inc}; // see R10 see R11 see R7
                    ack_nxt = 1'b1;
                    pg_nxt.mask[ptr_r[4:0]] = 1'b1; // see R8 see R9
                    pg_nxt.page = ptr_r[11:5];
                    pg_nxt.pending = 1'b1;
                end
                default: begin
                    st_nxt = sea_pkg::LK_IDLE;
                end
            endcase
        end else if (load_rd) begin
            // Twelve-bit pointer: rolls over inside this device only
            ptr_nxt = ptr_inc; // see R16 see R18 see R19 see R20 see R2
            first_nxt = 1'b0;
        end else if (at_ack && st_r == sea_pkg::LK_READ) begin
            st_nxt = sea_pkg::LK_IDLE; // see R19
        end
    end

    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            st_r <= sea_pkg::LK_IDLE;
            pg_r <= '0;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= sea_pkg::ADDR_ZERO;
            ack_r <= 1'b0;
            first_r <= 1'b0;
            start_seen_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pg_r <= pg_nxt;
            bit_r <= bit_nxt;
            shift_r <= byte_w;
            ptr_r <= ptr_nxt;
            ack_r <= ack_nxt;
            first_r <= first_nxt;
            start_seen_r <= start_tgl_r;
        end
    end

    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            tx_r <= 8'h00;
        end else if (load_rd) begin
            tx_r <= rd_q;
        end
    end

    // Busy flag and select straps brought onto the bus clock
    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            busy_m_r <= 1'b0;
            busy_s_r <= 1'b0;
            cs_m_r <= 3'h0;
            cs_s_r <= 3'h0;
        end else begin
            busy_m_r <= busy_r;
            busy_s_r <= busy_m_r;
            cs_m_r <= {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
            cs_s_r <= cs_m_r;
        end
    end

    // Data line changes only while scl is low
    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            oe_r <= 1'b0;
        end else begin
            oe_r <= drv_ack || drv_bit; // see R16
        end
    end

    assign sda_oe = oe_r;

    // Write engine on the system clock
    sea_pkg::sea_wr_st_t wst_r, wst_nxt;
    logic stop_m_r, stop_s_r, stop_d_r;
    logic wp_m_r, wp_s_r;
    logic [4:0] cp_idx_r, cp_idx_nxt;
    logic [4:0] wr_idx_r;
    logic wr_v_r;
    logic [31:0] cnt_r, cnt_nxt;
    logic sda_o_r;
    logic [7:0] buf_q;

    wire stop_pulse = stop_s_r ^ stop_d_r;
    // Page fields are steady here: the link refuses commands until busy clears
    wire commit = stop_pulse && pg_r.pending && !wp_s_r && wst_r == sea_pkg::WR_IDLE;
    wire arr_we = wr_v_r && pg_r.mask[wr_idx_r];
    wire [11:0] arr_waddr = {pg_r.page, wr_idx_r};
    wire cnt_done = cnt_r == 32'(WRITE_CYCLES - 1);

    always_comb begin
        wst_nxt = wst_r;
        cp_idx_nxt = cp_idx_r;
        cnt_nxt = cnt_r;
        unique case (wst_r)
            sea_pkg::WR_IDLE: begin
                if (commit) begin // see R5 see R6 see R12 see R13
                    wst_nxt = sea_pkg::WR_COPY;
                    cp_idx_nxt = 5'h00;
                end
            end
            sea_pkg::WR_COPY: begin
                cp_idx_nxt = cp_idx_r + 5'h01;
                if (cp_idx_r == sea_pkg::PAGE_END) begin
                    wst_nxt = sea_pkg::WR_WAIT;
                    cnt_nxt = 32'h0;
                end
            end
            sea_pkg::WR_WAIT: begin
                cnt_nxt = cnt_r + 32'h1;
                if (cnt_done) begin // see R24
                    wst_nxt = sea_pkg::WR_IDLE;
                end
            end
            default: begin
                wst_nxt = sea_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wst_r <= sea_pkg::WR_IDLE;
            cp_idx_r <= 5'h00;
            cnt_r <= 32'h0;
            busy_r <= 1'b0;
        end else begin
            wst_r <= wst_nxt;
            cp_idx_r <= cp_idx_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= wst_nxt != sea_pkg::WR_IDLE; // see R5
        end
    end

    // Untouched page bytes are not rewritten, so they keep their contents
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_v_r <= 1'b0;
            wr_idx_r <= 5'h00;
        end else begin
            wr_v_r <= wst_r == sea_pkg::WR_COPY; // see R8 see R9
            wr_idx_r <= cp_idx_r;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stop_m_r <= 1'b0;
            stop_s_r <= 1'b0;
            stop_d_r <= 1'b0;
            wp_m_r <= 1'b0;
            wp_s_r <= 1'b0;
            sda_o_r <= 1'b0;
        end else begin
            stop_m_r <= stop_tgl_r;
            stop_s_r <= stop_m_r;
            stop_d_r <= stop_s_r;
            wp_m_r <= write_protect;
            wp_s_r <= wp_m_r;
            sda_o_r <= 1'b0;
        end
    end

    assign sda_o = sda_o_r;
    assign write_busy = busy_r;

    sea_ram #(
        .AW(sea_pkg::ADDR_W),
        .DW(sea_pkg::DATA_W)
    ) u_array (
        .wclk(clock),
        .we(arr_we),
        .waddr(arr_waddr),
        .wdata(buf_q),
        .rclk(scl),
        .raddr(ptr_r),
        .rdata(rd_q)
    );

    sea_ram #(
        .AW(sea_pkg::PAGE_W),
        .DW(sea_pkg::DATA_W)
    ) u_page (
        .wclk(scl),
        .we(buf_we),
        .waddr(ptr_r[4:0]),
        .wdata(byte_w),
        .rclk(clock),
        .raddr(cp_idx_r),
        .rdata(buf_q)
    );

    AST_BUSY_NACK: assert property (@(posedge scl) disable iff (!rstn) // see R5
        (at_last && st_r == sea_pkg::LK_CTRL && busy_s_r) |=> (!ack_r && st_r == sea_pkg::LK_IDLE))
        else $error("control byte acked while busy");

    AST_CODE: assert property (@(posedge scl) disable iff (!rstn) // see R21
        (at_last && st_r == sea_pkg::LK_CTRL && !code_ok) |=> (st_r == sea_pkg::LK_IDLE && !ack_r))
        else $error("wrong device code accepted");

    AST_SELECT: assert property (@(posedge scl) disable iff (!rstn) // see R22
        (at_last && st_r == sea_pkg::LK_CTRL && !cs_ok) |=> (st_r == sea_pkg::LK_IDLE && !ack_r))
        else $error("select mismatch accepted");

    AST_ADDR_HIGH: assert property (@(posedge scl) disable iff (!rstn) // see R4
        (at_last && st_r == sea_pkg::LK_ADRH) |=> (ptr_r[11:8] == $past(byte_w[3:0]) && ack_r))
        else $error("high address not loaded");

    AST_PAGE_INC: assert property (@(posedge scl) disable iff (!rstn) // see R10
        (at_last && st_r == sea_pkg::LK_WDATA) |=>
        (ptr_r[11:5] == $past(ptr_r[11:5]) && ptr_r[4:0] == $past(ptr_r[4:0]) + 5'h01))
        else $error("page pointer step wrong");

    AST_RD_WRAP: assert property (@(posedge scl) disable iff (!rstn) // see R20
        (load_rd && ptr_r == sea_pkg::ADDR_TOP) |=> ptr_r == sea_pkg::ADDR_ZERO)
        else $error("read pointer did not roll over");

    AST_RD_NEXT: assert property (@(posedge scl) disable iff (!rstn) // see R18
        load_rd |=> (ptr_r == $past(ptr_r) + 12'h001 && tx_r == $past(rd_q)))
        else $error("read pointer or data wrong");

    AST_WP_BLOCK: assert property (@(posedge clock) disable iff (!rstn) // see R6
        (stop_pulse && wp_s_r && wst_r == sea_pkg::WR_IDLE) |=> (wst_r == sea_pkg::WR_IDLE && !write_busy))
        else $error("protected write started");

    AST_BUSY_HOLD: assert property (@(posedge clock) disable iff (!rstn) // see R24
        commit |=> write_busy [*8])
        else $error("write cycle ended too soon");

    AST_NO_STRAY: assert property (@(posedge clock) disable iff (!rstn) // see R9
        arr_we |-> (wst_r != sea_pkg::WR_IDLE && $past(wst_r) == sea_pkg::WR_COPY))
        else $error("array written outside commit");

endmodule
`default_nettype wire

// ===== hdl/sea_pkg.sv
// Constants, states and carriers of the serial EEPROM slave
// How it works
// R1 - Master may use select bits as A12-A14; here they must match the pins
// R2 - Reads never continue into another device
// R3 - Write control byte: code, selects, low R/W
// R4 - Ack control, then load high and low address
// R5 - Stop after data starts write; no acks meanwhile
// R6 - Protected write is acked but stores nothing
// R7 - After write, pointer sits above last byte
// R8 - Short write leaves rest of page intact
// R9 - Up to 32 bytes buffered, committed at stop
// R10 - Data bytes bump only low five pointer bits
// R11 - Page writes wrap inside their own page
// R12 - Protect pin high blocks the whole array
// R13 - Protect pin sampled once, at the stop
// R14 - Master polls with write control byte for ack
// R15 - Read control byte has R/W high
// R16 - Current read sends byte at pointer
// R17 - Random read: address write, restart, read
// R18 - After read, pointer sits past byte read
// R19 - Master ack asks for next byte; nack ends
// R20 - Pointer rolls from top address to zero
// R21 - Respond only to the device type code
// R22 - Respond only when select bits match pins
// R23 - Twelve address bits, high byte first
// R24 - Self-timed busy period: 32 copy cycles plus WRITE_CYCLES
`default_nettype none
package sea_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PAGE_W = 5;
    localparam int PAGE_N = 32;

    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [PAGE_W-1:0] PAGE_END = 5'h1F;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 12'hFFF;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;

    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_TIME_NS = 2000;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_CTRL = 3'b001,
        LK_ADRH = 3'b010,
        LK_ADRL = 3'b011,
        LK_WDATA = 3'b100,
        LK_READ = 3'b101
    } sea_link_st_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_COPY = 2'b01,
        WR_WAIT = 2'b10
    } sea_wr_st_t;

    // Page handed from the link side to the write engine
    typedef struct packed {
        logic pending;
        logic [ADDR_W-PAGE_W-1:0] page;
        logic [PAGE_N-1:0] mask;
    } sea_page_t;

endpackage
`default_nettype wire

// ===== hdl/sea_ram.sv
// Two-clock memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module sea_ram #(
    parameter int AW = 5,
    parameter int DW = 8
) (
    input wire logic wclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic rclk,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge wclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge rclk) begin
        rdata <= mem[raddr];
    end

endmodule
`default_nettype wire

// ===== tb/sea_master.sv
// Two-wire bus master model that drives clock and data for the slave
`timescale 1ns/1ps
`default_nettype none
module sea_master (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    localparam realtime Q = 7.5;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Start or repeated start; the clock stays high between frames
    task automatic start();
        sda_m = 1'b1;
        #Q scl = 1'b1;
        #Q sda_m = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask
    // Gap after stop keeps the next start clear of the write engine
    task automatic stop();
        sda_m = 1'b0;
        #Q scl = 1'b1;
        #Q sda_m = 1'b1;
        #100;
    endtask
    // Data moves a quarter period after the clock falls
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule
`default_nettype wire

// ===== tb/serial_eeprom_access_test.sv
// Self-checking bench of the serial EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_access_test;
    localparam int WCYC = 8;
    localparam logic [3:0] CODE = 4'h6; // Arbitrary value
    logic clock = 1'b0;
    logic rstn = 1'b1;
    logic [2:0] cs = 3'h5;
    logic wp = 1'b0;
    wire scl;
    wire sda_m;
    wire sda;
    logic sda_o;
    logic sda_oe;
    logic write_busy;
    int error_cnt = 0;
    int checked = 0;
    always #10 clock = ~clock;
    // Open-drain line with pull-up
    assign sda = sda_m & ~(sda_oe & ~sda_o);
    sea_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
    sea_eeprom #(.WRITE_CYCLES(WCYC), .DEV_CODE(CODE)) dut (
        .clock(clock), .rstn(rstn), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .chip_select_pin_0(cs[0]), .chip_select_pin_1(cs[1]), .chip_select_pin_2(cs[2]),
        .write_protect(wp), .write_busy(write_busy));
    task automatic finish_test();
        $display("Counts: %0d mismatches, %0d comparisons", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] ctl(input logic rw);
        return {CODE, cs, rw};
    endfunction
    task automatic wb(input logic [7:0] d, input logic exp);
        logic a;
        m.wbyte(d, a);
        chk({7'h00, a}, {7'h00, exp}, "ack");
    endtask
    // Upper nibble of the high address byte is noise
    task automatic adr(input logic [11:0] a);
        m.start();
        wb(ctl(1'b0), 1'b1);
        wb({4'hC, a[11:8]}, 1'b1);
        wb(a[7:0], 1'b1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d[$]);
        adr(a);
        foreach (d[i]) wb(d[i], 1'b1);
        m.stop();
    endtask
    // Fresh low reads from the pointer left by the last access
    task automatic rd(input logic fresh, input logic [11:0] a, input logic [7:0] e[$]);
        logic [7:0] d;
        if (fresh) adr(a);
        m.start();
        wb(ctl(1'b1), 1'b1);
        foreach (e[i]) begin
            m.rbyte(i < e.size() - 1, d);
            chk(d, e[i], "read data");
        end
        m.stop();
    endtask
    task automatic poll();
        logic a;
        int n;
        // Busy is looked at away from the edge that updates it
        repeat (6) @(negedge clock);
        chk({7'h00, write_busy}, 8'h01, "busy");
        n = 0;
        a = 1'b0;
        while (!a && n < 20) begin
            m.start();
            m.wbyte(ctl(1'b0), a);
            m.stop();
            if (n == 0) chk({7'h00, a}, 8'h00, "ack while busy");
            n++;
        end
        chk({7'h00, a}, 8'h01, "ack after write");
    endtask
    task automatic t_select();
        m.start();
        wb(ctl(1'b0) ^ 8'h80, 1'b0);
        for (int s = 0; s < 8; s++) begin
            @(negedge clock) cs = s[2:0];
            m.start();
            wb(ctl(1'b0) ^ 8'h02, 1'b0);
            m.start();
            wb(ctl(1'b0), 1'b1);
        end
        m.stop();
        @(negedge clock) cs = 3'h5;
    endtask
    task automatic t_page();
        wr(12'h3E1, '{8'h5A});
        poll();
        wr(12'h3FD, '{8'h11, 8'h22, 8'h33, 8'h44});
        poll();
        rd(1'b0, 12'h000, '{8'h5A});
        rd(1'b1, 12'h3E0, '{8'h44, 8'h5A});
        rd(1'b1, 12'h3FE, '{8'h22});
        rd(1'b0, 12'h000, '{8'h33});
    endtask
    task automatic t_over();
        logic [7:0] q[$];
        for (int i = 0; i <= 32; i++) q.push_back(8'(i) ^ 8'hA0);
        wr(12'h040, q);
        poll();
        rd(1'b0, 12'h000, '{8'hA1});
        rd(1'b1, 12'h05F, '{8'hBF});
        rd(1'b1, 12'h040, '{8'h80, 8'hA1});
    endtask
    task automatic t_wrap();
        wr(12'h000, '{8'h77});
        poll();
        wr(12'hFFF, '{8'h66});
        poll();
        rd(1'b1, 12'hFFF, '{8'h66, 8'h77});
    endtask
    task automatic t_protect();
        @(negedge clock) wp = 1'b1;
        wr(12'hFFF, '{8'h99});
        repeat (10) @(negedge clock);
        chk({7'h00, write_busy}, 8'h00, "busy when protected");
        @(negedge clock) wp = 1'b0;
        rd(1'b1, 12'hFFF, '{8'h66});
        wr(12'h000, '{8'h88});
        @(negedge clock) wp = 1'b1;
        poll();
        @(negedge clock) wp = 1'b0;
        rd(1'b1, 12'h000, '{8'h88});
    endtask
    initial begin
        // A real falling edge, so the flops on the idle bus clock reset too
        @(negedge clock) rstn = 1'b0;
        repeat (4) @(negedge clock);
        rstn = 1'b1;
        repeat (3) @(negedge clock);
        t_select();
        t_page();
        t_over();
        t_wrap();
        t_protect();
        finish_test();
    end
    initial begin
        #400us;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
